// [design/supply_enable_regs.vh]
// register offsets, field positions, reset values and defaults for the supply enable bank
`ifndef SUPPLY_ENABLE_REGS_VH
`define SUPPLY_ENABLE_REGS_VH

// printed offsets are register indices; byte address is four times the index
`define SUPPLY_REQ_INDEX       4'hD
`define SINK_EN_INDEX          4'hE
`define SUPPLY_STATUS_INDEX    4'hF
`define SUPPLY_REQ_ADDR        8'h34
`define SINK_EN_ADDR           8'h38
`define SUPPLY_STATUS_ADDR     8'h3C

`define FIRST_SWITCHER_BIT     0
`define SECOND_SWITCHER_BIT    1
`define THIRD_SWITCHER_BIT     2
`define FOURTH_SWITCHER_BIT    3
`define FIRST_LINEAR_BIT       8
`define SECOND_LINEAR_BIT      9
`define FIRST_SINK_BIT         0

// mask-programmed defaults
`define SUPPLY_REQ_RESET       16'h0000
`define SINK_EN_RESET          16'h0000
`define SUPPLY_REQ_MASK        16'h030F
`define SINK_EN_MASK           16'h0001

`define AXI_RESP_OKAY          2'h0
`define AXI_RESP_SLVERR        2'h2

`endif

// [design/enable_bit.v]
// one enable request bit with write, state machine reset and gated turn-on
`timescale 1ns/1ps
module enable_bit #(
	parameter RESET_VALUE = 1'b0
) (
	input  wire aclk,        // system clock
	input  wire aresetn,     // synchronous reset, active low
	input  wire sm_reset,    // power state machine reset pulse
	input  wire wr_en,       // software write strobe for this bit
	input  wire wr_data,     // value written by software
	input  wire permit,      // permission from state machine and fault logic
	output reg  request,     // stored request bit
	output reg  turn_on      // effective turn-on to the supply circuit
);

	always @(posedge aclk) begin
		if (!aresetn || sm_reset)
			request <= RESET_VALUE;
		else if (wr_en)
			request <= wr_data;
	end

	// registered so the supply sees a glitch-free level
	always @(posedge aclk) begin
		if (!aresetn)
			turn_on <= 1'b0;
		else
			turn_on <= request & permit;
	end

endmodule // enable_bit

// [design/supply_enable_control.v]
// AXI4-Lite register bank of supply and current sink enable requests
`timescale 1ns/1ps
`include "supply_enable_regs.vh"
module supply_enable_control (
	input  wire        aclk,                  // system clock, 100 MHz
	input  wire        aresetn,               // synchronous reset, active low
	input  wire [7:0]  s_axi_awaddr,          // write address
	input  wire        s_axi_awvalid,         // write address valid
	output wire        s_axi_awready,         // write address ready
	input  wire [31:0] s_axi_wdata,           // write data
	input  wire [3:0]  s_axi_wstrb,           // write byte strobes
	input  wire        s_axi_wvalid,          // write data valid
	output wire        s_axi_wready,          // write data ready
	output reg  [1:0]  s_axi_bresp,           // write response
	output reg         s_axi_bvalid,          // write response valid
	input  wire        s_axi_bready,          // write response ready
	input  wire [7:0]  s_axi_araddr,          // read address
	input  wire        s_axi_arvalid,         // read address valid
	output wire        s_axi_arready,         // read address ready
	output reg  [31:0] s_axi_rdata,           // read data
	output reg  [1:0]  s_axi_rresp,           // read response
	output reg         s_axi_rvalid,          // read data valid
	input  wire        s_axi_rready,          // read data ready
	input  wire        sm_reset,              // power state machine reset pulse
	input  wire [5:0]  supply_permit,         // permission per supply, bit order as status
	input  wire        sink_permit,           // permission for the current sink
	input  wire [5:0]  supply_actual,         // actual on state from supply circuits
	output wire        first_switcher_on,     // turn-on to first converter
	output wire        second_switcher_on,    // turn-on to second converter
	output wire        third_switcher_on,     // turn-on to third converter
	output wire        fourth_switcher_on,    // turn-on to fourth converter
	output wire        first_linear_reg_on,   // turn-on to first regulator
	output wire        second_linear_reg_on,  // turn-on to second regulator
	output wire        first_current_sink_on  // turn-on to sink driving current_sink_a_pin
);

	// write channel holding registers: address and data taken in either order
	reg         aw_held;
	reg  [7:0]  aw_addr;
	reg         w_held;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	wire        wr_fire;
	wire        wr_lane_ok;
	wire        wr_req_hit;
	wire        wr_sink_hit;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	// bits span both low bytes, so each lane gates its own bits
	assign wr_req_hit  = wr_fire && (aw_addr[7:2] == `SUPPLY_REQ_ADDR >> 2);
	assign wr_sink_hit = wr_fire && (aw_addr[7:2] == `SINK_EN_ADDR >> 2);
	assign wr_lane_ok  = (aw_addr[7:2] == `SUPPLY_REQ_ADDR >> 2)
		|| (aw_addr[7:2] == `SINK_EN_ADDR >> 2)
		|| (aw_addr[7:2] == `SUPPLY_STATUS_ADDR >> 2);

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AXI_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_lane_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// enable bits, one instance each
	wire [15:0] req_word;
	wire [15:0] sink_word;
	wire [6:0]  bit_we;
	wire [6:0]  bit_wd;
	wire [6:0]  bit_permit;
	wire [6:0]  bit_req;
	wire [6:0]  bit_on;

	// index 0..3 converters, 4..5 regulators, 6 sink
	assign bit_we[0] = wr_req_hit && w_strb[0];
	assign bit_we[1] = wr_req_hit && w_strb[0];
	assign bit_we[2] = wr_req_hit && w_strb[0];
	assign bit_we[3] = wr_req_hit && w_strb[0];
	assign bit_we[4] = wr_req_hit && w_strb[1];
	assign bit_we[5] = wr_req_hit && w_strb[1];
	assign bit_we[6] = wr_sink_hit && w_strb[0];
	assign bit_wd    = {w_data[`FIRST_SINK_BIT],
		w_data[`SECOND_LINEAR_BIT], w_data[`FIRST_LINEAR_BIT],
		w_data[`FOURTH_SWITCHER_BIT], w_data[`THIRD_SWITCHER_BIT],
		w_data[`SECOND_SWITCHER_BIT], w_data[`FIRST_SWITCHER_BIT]};
	assign bit_permit = {sink_permit, supply_permit};

	genvar i;
	generate
		for (i = 0; i < 7; i = i + 1) begin : g_bit
			enable_bit #(
				.RESET_VALUE (1'b0)
			) u_bit (
				.aclk     (aclk),
				.aresetn  (aresetn),
				.sm_reset (sm_reset),
				.wr_en    (bit_we[i]),
				.wr_data  (bit_wd[i]),
				.permit   (bit_permit[i]),
				.request  (bit_req[i]),
				.turn_on  (bit_on[i])
			);
		end
	endgenerate

	assign req_word = {6'h00, bit_req[5], bit_req[4], 4'h0, bit_req[3:0]};
	assign sink_word = {15'h0000, bit_req[6]};

	assign first_switcher_on     = bit_on[0];
	assign second_switcher_on    = bit_on[1];
	assign third_switcher_on     = bit_on[2];
	assign fourth_switcher_on    = bit_on[3];
	assign first_linear_reg_on   = bit_on[4];
	assign second_linear_reg_on  = bit_on[5];
	assign first_current_sink_on = bit_on[6];

	// actual supply state crosses from analog, three stages, change on agreement
	reg  [5:0]  act_s1;
	reg  [5:0]  act_s2;
	reg  [5:0]  act_s3;
	reg  [5:0]  act_state;
	wire [15:0] status_word;

	always @(posedge aclk) begin
		if (!aresetn) begin
			act_s1    <= 6'h00;
			act_s2    <= 6'h00;
			act_s3    <= 6'h00;
			act_state <= 6'h00;
		end else begin
			act_s1 <= supply_actual;
			act_s2 <= act_s1;
			act_s3 <= act_s2;
			act_state <= (act_s2 & act_s3) | (act_state & (act_s2 | act_s3));
		end
	end

	// status reads the supplies themselves, never the request bits
	assign status_word = {6'h00, act_state[5], act_state[4], 4'h0, act_state[3:0]};

	// read channel: one read under way, answer one cycle after address
	reg [15:0] next_rdata;
	reg        next_rok;

	assign s_axi_arready = !s_axi_rvalid;

	always @* begin
		next_rdata = 16'h0000;
		next_rok   = 1'b1;
		case (s_axi_araddr[7:2])
			`SUPPLY_REQ_ADDR >> 2:    next_rdata = req_word;
			`SINK_EN_ADDR >> 2:       next_rdata = sink_word;
			`SUPPLY_STATUS_ADDR >> 2: next_rdata = status_word;
			default:                  next_rok   = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `AXI_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {16'h0000, next_rdata};
			s_axi_rresp  <= next_rok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // supply_enable_control

// [tb/supply_enable_monitor.sv]
// assertion checker for the supply enable bank
`timescale 1ns/1ps
module supply_enable_monitor (
	input wire       aclk,                  // clock
	input wire       aresetn,               // sync reset, active low
	input wire       s_axi_arvalid,         // read address valid
	input wire       s_axi_arready,         // read address ready
	input wire       s_axi_rvalid,          // read data valid
	input wire       s_axi_bvalid,          // write response valid
	input wire       s_axi_bready,          // write response ready
	input wire       sm_reset,              // state machine reset
	input wire [5:0] supply_permit,         // supply permissions
	input wire       sink_permit,           // sink permission
	input wire       first_switcher_on,     // converter 1 turn-on
	input wire       fourth_switcher_on,    // converter 4 turn-on
	input wire       first_linear_reg_on,   // regulator 1 turn-on
	input wire       second_linear_reg_on,  // regulator 2 turn-on
	input wire       first_current_sink_on  // sink turn-on
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sink_gate_a: assert property (first_current_sink_on |-> $past(sink_permit))
		else $error("sink on without permission");
	refuse_off_a: assert property (!supply_permit[3] |=> !fourth_switcher_on)
		else $error("converter 4 on while refused");
	linear_gate_a: assert property (first_linear_reg_on |-> $past(supply_permit[4]))
		else $error("regulator 1 on without permission");
	sm_clear_a: assert property (sm_reset |-> ##2 !(first_switcher_on || second_linear_reg_on
		|| first_current_sink_on)) else $error("turn-on survives state machine reset");
	reset_zero_a: assert property ($rose(aresetn) |-> !first_switcher_on && !first_current_sink_on)
		else $error("turn-on set after reset");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	sink_on_c: cover property (first_current_sink_on);
	refused_c: cover property (!supply_permit[3] ##1 supply_permit[3]);
	sm_pulse_c: cover property (sm_reset && first_switcher_on);
endmodule // supply_enable_monitor
bind supply_enable_control supply_enable_monitor supply_enable_monitor_i (.aclk, .aresetn,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .sm_reset,
	.supply_permit, .sink_permit, .first_switcher_on, .fourth_switcher_on,
	.first_linear_reg_on, .second_linear_reg_on, .first_current_sink_on);

// [tb/tb.sv]
// self-checking bench for the supply enable bank
`timescale 1ns/1ps
module tb;
	logic aclk = 0, aresetn = 0, sm_reset = 0, sink_permit = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [5:0] supply_permit = 0, supply_actual = 0;
	wire first_switcher_on, second_switcher_on, third_switcher_on, fourth_switcher_on;
	wire first_linear_reg_on, second_linear_reg_on, first_current_sink_on;
	wire [6:0] ons = {first_current_sink_on, second_linear_reg_on, first_linear_reg_on,
		fourth_switcher_on, third_switcher_on, second_switcher_on, first_switcher_on};
	int bad_count = 0, checks = 0, cyc = 0;
	supply_enable_control supply_enable_control_i (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .sm_reset, .supply_permit, .sink_permit, .supply_actual,
		.first_switcher_on, .second_switcher_on, .third_switcher_on, .fourth_switcher_on,
		.first_linear_reg_on, .second_linear_reg_on, .first_current_sink_on);
	initial forever #5 aclk = ~aclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a; s_axi_wdata <= d;
		s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk(s_axi_bresp, er);
		@(posedge aclk);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		chk(s_axi_rdata, ed);
		chk(s_axi_rresp, er);
		@(posedge aclk);
	endtask
	task automatic t_reset;
		axr(8'h34, 32'h0, 2'h0);
		axr(8'h38, 32'h0, 2'h0);
		chk(ons, 7'h00);
		$display("test reset done");
	endtask
	task automatic t_bits;
		supply_permit <= 6'h3F;
		axw(8'h34, 32'hFFFFFFFF, 2'h0);
		axr(8'h34, 32'h30F, 2'h0);
		chk(ons, 7'h3F);
		axw(8'h34, 32'h205, 2'h0);
		axr(8'h34, 32'h205, 2'h0);
		chk(ons, 7'h25);
		$display("test bits done");
	endtask
	task automatic t_refuse;
		supply_permit <= 6'h1A;
		repeat (2) @(posedge aclk);
		axr(8'h34, 32'h205, 2'h0);
		chk(ons, 7'h00);
		$display("test refuse done");
	endtask
	task automatic t_status;
		supply_actual <= 6'h2A;
		repeat (6) @(posedge aclk);
		axr(8'h3C, 32'h20A, 2'h0);
		axw(8'h40, 32'h1, 2'h2);
		axr(8'h40, 32'h0, 2'h2);
		$display("test status done");
	endtask
	task automatic t_sink;
		sink_permit <= 1; supply_permit <= 6'h3F;
		axw(8'h38, 32'hFFFF, 2'h0);
		axr(8'h38, 32'h1, 2'h0);
		chk(ons, 7'h65);
		sm_reset <= 1;
		@(posedge aclk);
		sm_reset <= 0;
		axr(8'h34, 32'h0, 2'h0);
		axr(8'h38, 32'h0, 2'h0);
		chk(ons, 7'h00);
		// low lane only: the regulator bits in byte one must stay clear
		s_axi_wstrb <= 4'h1;
		axw(8'h34, 32'h30F, 2'h0);
		s_axi_wstrb <= 4'hF;
		axr(8'h34, 32'h00F, 2'h0);
		$display("test sink done");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			bad_count++;
			$display("[ERR] %0t timeout", $time);
			print_verdict();
		end
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_reset();
		t_bits();
		t_refuse();
		t_status();
		t_sink();
		print_verdict();
	end
endmodule // tb
